/* logic/tmrc_checker.sv */
`timescale 1ns/1ps
module tmrc_checker
  import tmrc_pkg::*;
#(
  parameter logic [4:0] DN1_DEV = 5'h01,
  parameter logic [4:0] DN2_DEV = 5'h02
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire tmrc_ing_t i_ing,
  input wire tmrc_egr_t i_egr,
  output tmrc_rep_t o_ing_err,
  output tmrc_rep_t o_egr_err
);
  logic [3:0] cmd [NUM_PORTS];
  logic [7:0] tcmap [NUM_PORTS];
  logic [31:0] switch_control_word;
  logic [15:0] cnt_mal;
  logic [15:0] cnt_ur;
  logic [15:0] cnt_uc;
  logic [7:0] last_err;
  logic acc_ack;
  logic wr_fire;
  logic [31:0] next_rdata;
  logic [31:0] be_mask;
  tmrc_err_t next_cls;
  logic [4:0] dev_of_port [NUM_PORTS];

  assign dev_of_port[0] = DEV_ZERO;
  assign dev_of_port[1] = DN1_DEV;
  assign dev_of_port[2] = DN2_DEV;

  // bus slave: one wait cycle, transfer at the edge where waitrequest is low
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~acc_ack;
  assign wr_fire = i_avs_write & acc_ack;
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_ack <= 1'b0;
    end else begin
      acc_ack <= (i_avs_read | i_avs_write) & ~acc_ack;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (i_avs_address == CMD_BASE + 12'(4 * p)) begin
        next_rdata = {28'h0000000, cmd[p]};
      end
      if (i_avs_address == MAP_BASE + 12'(4 * p)) begin
        next_rdata = {24'h000000, tcmap[p]};
      end
    end
    case (i_avs_address)
      CNT_MAL_ADDR: next_rdata = {16'h0000, cnt_mal};
      CNT_UR_ADDR: next_rdata = {16'h0000, cnt_ur};
      CNT_UC_ADDR: next_rdata = {16'h0000, cnt_uc};
      LAST_ERR_ADDR: next_rdata = {24'h000000, last_err};
      SWITCH_CONTROL_WORD_ADDR: next_rdata = switch_control_word;
      default: ;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~acc_ack) begin
      o_avs_readdata <= next_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      switch_control_word <= SWITCH_CONTROL_WORD_RESET;
      for (int p = 0; p < NUM_PORTS; p++) begin
        cmd[p] <= CMD_RESET;
        tcmap[p] <= MAP_RESET;
      end
    end else if (wr_fire) begin
      if (i_avs_address == SWITCH_CONTROL_WORD_ADDR) begin
        switch_control_word <= (switch_control_word & ~be_mask) | (i_avs_writedata & be_mask);
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (i_avs_address == CMD_BASE + 12'(4 * p) && i_avs_byteenable[0]) begin
          cmd[p] <= i_avs_writedata[3:0];
        end
        if (i_avs_address == MAP_BASE + 12'(4 * p) && i_avs_byteenable[0]) begin
          tcmap[p] <= i_avs_writedata[7:0];
        end
      end
    end
  end

  // ingress classification; malformed checks take priority over routing
  logic is_iocfg;
  logic from_up;
  logic tgt_up;
  logic mal;
  logic ur;
  logic uc;
  logic drop;
  logic tgt_dev_ok;

  always_comb begin
    is_iocfg = i_ing.kind == K_IO || i_ing.kind == K_CFG0 || i_ing.kind == K_CFG1;
    from_up = i_ing.rx_port == UP_PORT;
    tgt_up = i_ing.tgt_port == UP_PORT;
    tgt_dev_ok = 1'b0;
    for (int p = 1; p < NUM_PORTS; p++) begin
      if (dev_of_port[p] == i_ing.dev_num && cmd[p] != CMD_RESET) begin
        tgt_dev_ok = 1'b1;
      end
    end
    mal = 1'b0;
    ur = 1'b0;
    uc = 1'b0;
    drop = 1'b0;
    if (is_iocfg && (i_ing.length != IO_CFG_LEN || i_ing.tc != TC_ZERO || i_ing.attr != ATTR_ZERO
        || i_ing.last_be != LAST_BE_NONE)) begin
      mal = 1'b1;
    end
    if (i_ing.kind == K_MSG && i_ing.tc != TC_ZERO && (i_ing.msg == M_INTX || i_ing.msg == M_PM
        || i_ing.msg == M_ERR || i_ing.msg == M_UNLOCK || i_ing.msg == M_SPL)) begin
      mal = 1'b1;
    end
    if (from_up && (i_ing.route == RT_TO_ROOT || (i_ing.kind == K_MSG && i_ing.msg == M_INTX))) begin
      mal = 1'b1;
    end
    if (!from_up && i_ing.route == RT_BCAST) begin
      mal = 1'b1;
    end
    if (i_ing.route == RT_GATHER && (from_up || i_ing.kind != K_MSG || i_ing.msg != M_PME_ACK)) begin
      mal = 1'b1;
    end
    if (i_ing.trusted_cfg && !from_up) begin
      mal = 1'b1;
    end
    if (!tcmap[i_ing.rx_port][i_ing.tc]) begin
      mal = 1'b1;
    end
    // routing failures: unsupported request, except internal completions (unexpected) and vendor type 1 messages (drop)
    if (i_ing.kind == K_MEM || i_ing.kind == K_IO) begin
      if (i_ing.tgt_port == i_ing.rx_port) begin
        ur = 1'b1;
      end
      if (from_up && i_ing.up_range_hit && !i_ing.route_ok) begin
        ur = 1'b1;
      end
      if (!tgt_up && ((i_ing.kind == K_MEM && !cmd[i_ing.tgt_port][CMD_MAE])
          || (i_ing.kind == K_IO && !cmd[i_ing.tgt_port][CMD_IO_ACCESS_ENABLE_BIT]))) begin
        ur = 1'b1;
      end
      if (!from_up && (!cmd[i_ing.rx_port][CMD_BME] || (tgt_up && !cmd[UP_PORT][CMD_BME]))) begin
        ur = 1'b1;
      end
      if (!from_up && i_ing.vga_route && cmd[i_ing.rx_port][CMD_VGAE]) begin
        ur = 1'b1;
      end
    end
    if (i_ing.kind == K_CFG0 || i_ing.kind == K_CFG1) begin
      if (!from_up) begin
        ur = 1'b1;
      end
      if (i_ing.kind == K_CFG1 && !i_ing.cfg_through_up) begin
        ur = 1'b1;
      end
      if (i_ing.kind == K_CFG1 && i_ing.cfg_conv_up && !tgt_dev_ok) begin
        ur = 1'b1;
      end
      if (i_ing.kind == K_CFG1 && i_ing.cfg_conv_dn && i_ing.dev_num != DEV_ZERO && !switch_control_word[SW_DZCD]) begin
        ur = 1'b1;
      end
    end
    if (i_ing.kind == K_CPL) begin
      if (i_ing.tgt_internal) begin
        uc = 1'b1;
      end else if (i_ing.tgt_port == i_ing.rx_port || !i_ing.route_ok) begin
        ur = 1'b1;
      end
    end
    if (i_ing.kind == K_MSG && i_ing.route == RT_ID) begin
      if (i_ing.tgt_port == i_ing.rx_port || !i_ing.route_ok || (!tgt_up && !tgt_dev_ok)) begin
        ur = 1'b1;
      end
    end
    if (i_ing.kind == K_MSG && i_ing.type1_msg) begin
      if (i_ing.msg == M_VENDOR) begin
        drop = 1'b1;
      end else if (from_up || cmd[i_ing.tgt_port] != CMD_RESET) begin
        ur = 1'b1;
      end
    end
    if (mal) begin
      next_cls = E_MALFORMED;
    end else if (ur) begin
      next_cls = E_UNSUPPORTED;
    end else if (uc) begin
      next_cls = E_UNEXP_CPL;
    end else if (drop) begin
      next_cls = E_DROP;
    end else begin
      next_cls = E_NONE;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ing_err <= '0;
    end else begin
      o_ing_err.valid <= i_ing.valid && next_cls != E_NONE;
      o_ing_err.cls <= i_ing.valid ? next_cls : E_NONE;
      o_ing_err.advisory <= i_ing.valid && next_cls == E_UNSUPPORTED && i_ing.non_posted;
      o_ing_err.port <= i_ing.rx_port;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_egr_err <= '0;
    end else begin
      o_egr_err.valid <= i_egr.valid && !tcmap[i_egr.port][i_egr.tc];
      o_egr_err.cls <= (i_egr.valid && !tcmap[i_egr.port][i_egr.tc]) ? E_MALFORMED : E_NONE;
      o_egr_err.advisory <= 1'b0;
      o_egr_err.port <= i_egr.port;
    end
  end

  // error tallies, saturating
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_mal <= 16'h0000;
      cnt_ur <= 16'h0000;
      cnt_uc <= 16'h0000;
      last_err <= 8'h00;
    end else begin
      if (o_ing_err.valid && o_ing_err.cls == E_MALFORMED && cnt_mal != 16'hffff) begin
        cnt_mal <= cnt_mal + 16'h0001;
      end
      if (o_ing_err.valid && o_ing_err.cls == E_UNSUPPORTED && cnt_ur != 16'hffff) begin
        cnt_ur <= cnt_ur + 16'h0001;
      end
      if (o_ing_err.valid && o_ing_err.cls == E_UNEXP_CPL && cnt_uc != 16'hffff) begin
        cnt_uc <= cnt_uc + 16'h0001;
      end
      if (o_ing_err.valid) begin
        last_err <= {2'h0, o_ing_err.port, o_ing_err.advisory, o_ing_err.cls};
      end
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_io_len_mal: assert property (i_ing.valid && i_ing.kind == K_IO && i_ing.length != IO_CFG_LEN
    |=> o_ing_err.valid && o_ing_err.cls == E_MALFORMED) else $error("io length not malformed");
  a_msg_tc_mal: assert property (i_ing.valid && i_ing.kind == K_MSG && i_ing.msg == M_ERR
    && i_ing.tc != TC_ZERO |=> o_ing_err.cls == E_MALFORMED) else $error("msg tc not malformed");
  a_bcast_dn_mal: assert property (i_ing.valid && i_ing.route == RT_BCAST
    && i_ing.rx_port != UP_PORT |=> o_ing_err.cls == E_MALFORMED) else $error("bcast from downstream");
  a_ing_map_mal: assert property (i_ing.valid && !tcmap[i_ing.rx_port][i_ing.tc]
    |=> o_ing_err.valid && o_ing_err.cls == E_MALFORMED) else $error("unmapped tc passed");
  a_egr_map_err: assert property (i_egr.valid && !tcmap[i_egr.port][i_egr.tc]
    |=> o_egr_err.valid) else $error("egress unmapped tc passed");
  a_cfg_dn_ur: assert property (i_ing.valid && i_ing.kind == K_CFG0 && i_ing.rx_port != UP_PORT
    && !mal |=> o_ing_err.cls == E_UNSUPPORTED) else $error("cfg downstream not ur");
  a_adv_np_ur: assert property (o_ing_err.advisory |-> o_ing_err.valid
    && o_ing_err.cls == E_UNSUPPORTED) else $error("advisory without ur");
  a_err_one_pulse: assert property (!i_ing.valid |=> !o_ing_err.valid) else $error("error without packet");
  a_uc_class: assert property (i_ing.valid && i_ing.kind == K_CPL && i_ing.tgt_internal
    && !mal |=> o_ing_err.cls == E_UNEXP_CPL) else $error("internal cpl not unexpected");
  a_bus_wait_one: assert property ((i_avs_read || i_avs_write) && !acc_ack
    |=> !o_avs_waitrequest || !(i_avs_read || i_avs_write)) else $error("bus answer late");

  c_malformed: cover property (o_ing_err.valid && o_ing_err.cls == E_MALFORMED);
  c_unsupported: cover property (o_ing_err.valid && o_ing_err.cls == E_UNSUPPORTED);
  c_drop: cover property (o_ing_err.valid && o_ing_err.cls == E_DROP);
  c_switch_control_word_write: cover property (wr_fire && i_avs_address == SWITCH_CONTROL_WORD_ADDR);
endmodule // tmrc_checker

/* common/tmrc_pkg.sv */
package tmrc_pkg;
  localparam int NUM_PORTS = 3;
  localparam logic [1:0] UP_PORT = 2'h0;
  localparam logic [9:0] IO_CFG_LEN = 10'h001;
  localparam logic [3:0] LAST_BE_NONE = 4'h0;
  localparam logic [2:0] TC_ZERO = 3'h0;
  localparam logic [1:0] ATTR_ZERO = 2'h0;
  localparam logic [4:0] DEV_ZERO = 5'h00;
  // register byte addresses
  localparam logic [11:0] CMD_BASE = 12'h000;
  localparam logic [11:0] MAP_BASE = 12'h010;
  localparam logic [11:0] CNT_MAL_ADDR = 12'h020;
  localparam logic [11:0] CNT_UR_ADDR = 12'h024;
  localparam logic [11:0] CNT_UC_ADDR = 12'h028;
  localparam logic [11:0] LAST_ERR_ADDR = 12'h02c;
  localparam logic [11:0] SWITCH_CONTROL_WORD_ADDR = 12'h404;
  // fields
  localparam int CMD_IO_ACCESS_ENABLE_BIT = 0;
  localparam int CMD_MAE = 1;
  localparam int CMD_BME = 2;
  localparam int CMD_VGAE = 3;
  localparam int SW_DZCD = 0;
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam logic [7:0] MAP_RESET = 8'h01;
  localparam logic [31:0] SWITCH_CONTROL_WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {K_MEM, K_IO, K_CFG0, K_CFG1, K_CPL, K_MSG} tmrc_kind_t;
  typedef enum logic [2:0] {RT_ADDR, RT_ID, RT_TO_ROOT, RT_BCAST, RT_LOCAL, RT_GATHER} tmrc_route_t;
  typedef enum logic [2:0] {M_INTX, M_PM, M_ERR, M_UNLOCK, M_SPL, M_PME_ACK, M_VENDOR, M_OTHER} tmrc_msg_t;
  typedef enum logic [2:0] {E_NONE, E_MALFORMED, E_UNSUPPORTED, E_UNEXP_CPL, E_DROP} tmrc_err_t;

  typedef struct packed {
    logic valid;
    tmrc_kind_t kind;
    tmrc_route_t route;
    tmrc_msg_t msg;
    logic non_posted;
    logic trusted_cfg;
    logic type1_msg;
    logic [1:0] rx_port;
    logic [9:0] length;
    logic [2:0] tc;
    logic [1:0] attr;
    logic [3:0] last_be;
    logic [1:0] tgt_port;
    logic route_ok;
    logic up_range_hit;
    logic vga_route;
    logic cfg_through_up;
    logic cfg_conv_up;
    logic cfg_conv_dn;
    logic tgt_internal;
    logic [4:0] dev_num;
  } tmrc_ing_t;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic [2:0] tc;
  } tmrc_egr_t;

  typedef struct packed {
    logic valid;
    tmrc_err_t cls;
    logic advisory;
    logic [1:0] port;
  } tmrc_rep_t;
endpackage

/* verif/tmrc_link_model.sv */
`timescale 1ns/1ps
module tmrc_link_model
  import tmrc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  input wire tmrc_ing_t i_pkt,
  input wire logic i_ego,
  input wire tmrc_egr_t i_epkt,
  output tmrc_ing_t o_ing,
  output tmrc_egr_t o_egr
);
  // fields toggle between packets so stale values never look live
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ing <= '0;
      o_egr <= '0;
    end else begin
      o_ing <= i_go ? i_pkt : ~o_ing;
      o_ing.valid <= i_go;
      o_egr <= i_ego ? i_epkt : ~o_egr;
      o_egr.valid <= i_ego;
    end
  end
endmodule // tmrc_link_model

/* verif/tlp_malformed_and_route_check_tb_top.sv */
`timescale 1ns/1ps
module tlp_malformed_and_route_check_tb_top;
  import tmrc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic wreq;
  logic go = 1'b0;
  logic ego = 1'b0;
  tmrc_ing_t pkt = '0;
  tmrc_egr_t epkt = '0;
  tmrc_ing_t ing;
  tmrc_egr_t egr;
  tmrc_rep_t ierr;
  tmrc_rep_t eerr;
  logic ipend;
  logic epend;
  logic [5:0] qi[$];
  logic [2:0] qe[$];
  logic [5:0] xi;
  logic [2:0] xe;
  logic [15:0] nm = '0;
  logic [15:0] nu = '0;
  logic [15:0] nc = '0;
  int failures = 0;
  int check_count = 0;
  tmrc_ing_t p;
  tmrc_checker i_tmrc_checker (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_ing(ing), .i_egr(egr), .o_ing_err(ierr), .o_egr_err(eerr));
  tmrc_link_model i_tmrc_link_model (.i_ref_clk(clk), .i_sys_rst(rst), .i_go(go), .i_pkt(pkt),
    .i_ego(ego), .i_epkt(epkt), .o_ing(ing), .o_egr(egr));
  initial begin
    forever #10 clk = ~clk;
  end
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge; data taken and request dropped there
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task rreg(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(n, e, q);
  endtask
  task send(input tmrc_ing_t s, input tmrc_err_t e);
    qi.push_back({e, s.non_posted & (e == E_UNSUPPORTED), s.rx_port});
    if (e == E_MALFORMED) nm++;
    if (e == E_UNSUPPORTED) nu++;
    if (e == E_UNEXP_CPL) nc++;
    @(posedge clk);
    pkt <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task esend(input logic [1:0] pt, input logic [2:0] tc, input logic bad);
    qe.push_back({bad, pt});
    @(posedge clk);
    epkt <= '{1'b1, pt, tc};
    ego <= 1'b1;
    @(posedge clk);
    ego <= 1'b0;
  endtask
  function automatic tmrc_ing_t mk(tmrc_kind_t k, tmrc_route_t r, tmrc_msg_t g, logic [1:0] x, logic [1:0] t);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.route = r;
    mk.msg = g;
    mk.rx_port = x;
    mk.tgt_port = t;
    mk.length = IO_CFG_LEN;
    mk.route_ok = 1'b1;
  endfunction
  always @(posedge clk) begin
    ipend <= ing.valid;
    epend <= egr.valid;
  end
  always @(negedge clk) begin
    if (!rst && ipend === 1'b1) begin
      xi = qi.pop_front();
      chk("ing_valid", {31'h0, xi[5:3] != E_NONE}, {31'h0, ierr.valid});
      if (xi[5:3] != E_NONE) begin
        chk("ing_cls", xi[5:3], ierr.cls);
        chk("ing_port", xi[1:0], ierr.port);
        chk("ing_adv", xi[2], ierr.advisory);
      end
    end else if (!rst) chk("ing_idle", 32'h0, ierr.valid);
    if (!rst && epend === 1'b1) begin
      xe = qe.pop_front();
      chk("egr_valid", xe[2], eerr.valid);
      if (xe[2]) chk("egr_cls", E_MALFORMED, eerr.cls);
      chk("egr_port", xe[1:0], eerr.port);
      chk("egr_adv", 32'h0, eerr.advisory);
    end else if (!rst) chk("egr_idle", 32'h0, eerr.valid);
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(32));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg("cmd0", CMD_BASE, 32'h0);
    rreg("map2", MAP_BASE + 12'h008, 32'h1);
    rreg("switch_control_word", SWITCH_CONTROL_WORD_ADDR, 32'h0);
    rreg("unmapped", 12'h100, 32'h0);
    for (int i = 0; i < 3; i++) wreg(CMD_BASE + 12'(4 * i), 32'hf);
    wreg(MAP_BASE + 12'h004, 32'hff);
    p = mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h2);
    for (int i = 0; i < 4; i++) begin
      p.tc = 3'($urandom);
      send(p, E_NONE);
    end
    p = mk(K_MEM, RT_ADDR, M_OTHER, 2'h2, 2'h1);
    p.tc = 3'h1;
    send(p, E_MALFORMED);
    p = mk(K_IO, RT_ADDR, M_OTHER, 2'h1, 2'h2);
    send(p, E_NONE);
    p.length = 10'h002;
    send(p, E_MALFORMED);
    p.length = IO_CFG_LEN;
    p.last_be = 4'h1;
    send(p, E_MALFORMED);
    p.last_be = LAST_BE_NONE;
    p.attr = 2'h1;
    send(p, E_MALFORMED);
    p.attr = ATTR_ZERO;
    p.tc = 3'h1;
    send(p, E_MALFORMED);
    for (int g = 0; g < 5; g++) begin
      p = mk(K_MSG, RT_TO_ROOT, tmrc_msg_t'(g), 2'h1, 2'h0);
      p.tc = 3'h1;
      send(p, E_MALFORMED);
    end
    send(mk(K_MSG, RT_TO_ROOT, M_OTHER, 2'h0, 2'h1), E_MALFORMED);
    send(mk(K_MSG, RT_LOCAL, M_INTX, 2'h0, 2'h0), E_MALFORMED);
    send(mk(K_MSG, RT_BCAST, M_OTHER, 2'h1, 2'h1), E_MALFORMED);
    send(mk(K_MSG, RT_GATHER, M_PM, 2'h1, 2'h0), E_MALFORMED);
    send(mk(K_MSG, RT_GATHER, M_PME_ACK, 2'h0, 2'h0), E_MALFORMED);
    send(mk(K_MSG, RT_GATHER, M_PME_ACK, 2'h1, 2'h0), E_NONE);
    p = mk(K_CFG0, RT_ID, M_OTHER, 2'h1, 2'h0);
    p.trusted_cfg = 1'b1;
    send(p, E_MALFORMED);
    p = mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h1);
    p.non_posted = 1'b1;
    send(p, E_UNSUPPORTED);
    p = mk(K_MEM, RT_ADDR, M_OTHER, 2'h0, 2'h1);
    p.up_range_hit = 1'b1;
    p.route_ok = 1'b0;
    send(p, E_UNSUPPORTED);
    wreg(CMD_BASE + 12'h008, 32'h6);
    send(mk(K_IO, RT_ADDR, M_OTHER, 2'h1, 2'h2), E_UNSUPPORTED);
    wreg(CMD_BASE + 12'h008, 32'h5);
    send(mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h2), E_UNSUPPORTED);
    wreg(CMD_BASE + 12'h008, 32'hf);
    wreg(CMD_BASE + 12'h004, 32'h3);
    send(mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h2), E_UNSUPPORTED);
    wreg(CMD_BASE + 12'h004, 32'hf);
    wreg(CMD_BASE, 32'h3);
    send(mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h0), E_UNSUPPORTED);
    wreg(CMD_BASE, 32'hf);
    p = mk(K_MEM, RT_ADDR, M_OTHER, 2'h1, 2'h0);
    p.vga_route = 1'b1;
    send(p, E_UNSUPPORTED);
    send(mk(K_CFG0, RT_ID, M_OTHER, 2'h1, 2'h0), E_UNSUPPORTED);
    send(mk(K_CFG1, RT_ID, M_OTHER, 2'h0, 2'h1), E_UNSUPPORTED);
    p = mk(K_CFG1, RT_ID, M_OTHER, 2'h0, 2'h1);
    p.cfg_through_up = 1'b1;
    p.cfg_conv_up = 1'b1;
    p.dev_num = 5'h01;
    send(p, E_NONE);
    p.dev_num = 5'h03;
    send(p, E_UNSUPPORTED);
    p.cfg_conv_up = 1'b0;
    p.cfg_conv_dn = 1'b1;
    p.dev_num = 5'h01;
    send(p, E_UNSUPPORTED);
    wreg(SWITCH_CONTROL_WORD_ADDR, 32'h1);
    rreg("switch_control_word", SWITCH_CONTROL_WORD_ADDR, 32'h1);
    send(p, E_NONE);
    p = mk(K_CPL, RT_ID, M_OTHER, 2'h1, 2'h1);
    send(p, E_UNSUPPORTED);
    p.tgt_port = 2'h0;
    p.route_ok = 1'b0;
    send(p, E_UNSUPPORTED);
    p.route_ok = 1'b1;
    p.tgt_internal = 1'b1;
    send(p, E_UNEXP_CPL);
    send(mk(K_MSG, RT_ID, M_OTHER, 2'h1, 2'h1), E_UNSUPPORTED);
    p = mk(K_MSG, RT_ID, M_OTHER, 2'h1, 2'h2);
    p.dev_num = 5'h07;
    send(p, E_UNSUPPORTED);
    p = mk(K_MSG, RT_LOCAL, M_OTHER, 2'h0, 2'h0);
    p.type1_msg = 1'b1;
    send(p, E_UNSUPPORTED);
    p.msg = M_VENDOR;
    send(p, E_DROP);
    esend(2'h2, 3'h1, 1'b1);
    esend(2'h1, 3'h1, 1'b0);
    repeat (3) @(posedge clk);
    rreg("cnt_mal", CNT_MAL_ADDR, {16'h0, nm});
    rreg("cnt_ur", CNT_UR_ADDR, {16'h0, nu});
    rreg("cnt_uc", CNT_UC_ADDR, {16'h0, nc});
    rreg("last_err", LAST_ERR_ADDR, {26'h0, 2'h0, 1'b0, E_DROP});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg("cmd1", CMD_BASE + 12'h004, 32'h0);
    rreg("cnt_mal_rst", CNT_MAL_ADDR, 32'h0);
    finish_test;
  end
endmodule // tlp_malformed_and_route_check_tb_top
